// ===== core/docr_consts.vh
// Behaviour
// (RULE1) The low two bits of the differential-output register choose off, PECL or LVDS drive.
// (RULE2) Code 01 gives PECL, code 10 gives LVDS, codes 00 and 11 leave the driver disabled.
// (RULE3) Bandwidth bit 7 set lets the loop pick locked or acquisition bandwidth, clear forces locked.
// (RULE4) With the limit bit 3 set the integral path freezes at a frequency limit, clear never.
// (RULE5) While the integral path is frozen the reported PLL frequency is held constant.
// (RULE6) The calibration low byte joins the upper byte [15:8] into one 16-bit unsigned trim word.
`ifndef DOCR_CONSTS_VH
`define DOCR_CONSTS_VH
`define DOCR_ADDR_DIFF_OUT   8'h3A
`define DOCR_ADDR_BW_CTRL    8'h3B
`define DOCR_ADDR_CAL_LO     8'h3C
`define DOCR_ADDR_CAL_HI     8'h3D
`define DOCR_RST_DIFF_OUT    8'hC2
`define DOCR_RST_BW_CTRL     8'h98
`define DOCR_RST_CAL_LO      8'h99
`define DOCR_RST_CAL_HI      8'h99
`define DOCR_BIT_AUTO_BW     7
`define DOCR_BIT_LIM_INT     3
`define DOCR_MASK_DIFF_OUT   8'h03
`define DOCR_MASK_BW_CTRL    8'h88
`define DOCR_SIG_PECL        2'b01
`define DOCR_SIG_LVDS        2'b10
`endif

// ===== core/docr_regs.v
`timescale 1ns/1ns
`include "docr_consts.vh"
// Configuration slice: output type, bandwidth policy, integrator freeze, calibration.
module docr_regs (
  // Clock and asynchronous reset
  input  wire        ref_clk,
  input  wire        resetn,
  // Register access port, one strobe per access
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Upper calibration byte from the adjacent register
  input  wire [7:0]  cal_high_byte,
  // Loop status from the PLL datapath
  input  wire        pll_locked,
  input  wire        freq_at_limit,
  input  wire [15:0] pll_freq_live,
  // Differential output driver mode
  output reg         diff_out_enable,
  output reg         diff_out_pecl,
  output reg         diff_out_lvds,
  // Loop bandwidth and integrator control
  output reg         use_acq_bandwidth,
  output reg         integrator_frozen,
  output reg  [15:0] reported_pll_frequency,
  // Oscillator trim word for the PLL
  output reg  [15:0] osc_trim_word
);

  // One-hot register select codes, with all-zero SEL_NONE for no register
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_DIFF = 3'h1;
  localparam [2:0] SEL_BW   = 3'h2;
  localparam [2:0] SEL_CAL  = 3'h4;

  // Driver mode decode, shared by the mode lines and the enable
  function docr_is_pecl;
    input [1:0] code;
    begin
      docr_is_pecl = (code == `DOCR_SIG_PECL);
    end
  endfunction

  function docr_is_lvds;
    input [1:0] code;
    begin
      docr_is_lvds = (code == `DOCR_SIG_LVDS);
    end
  endfunction

  // Codes 00 and 11 both leave the driver off, so only two codes enable it
  function docr_is_driven;
    input [1:0] code;
    begin
      docr_is_driven = docr_is_pecl(code) | docr_is_lvds(code);
    end
  endfunction

  // Register select, shared by the write and read paths
  function [2:0] docr_sel;
    input [7:0] addr;
    begin
      case (addr)
        `DOCR_ADDR_DIFF_OUT: docr_sel = SEL_DIFF;
        `DOCR_ADDR_BW_CTRL:  docr_sel = SEL_BW;
        `DOCR_ADDR_CAL_LO:   docr_sel = SEL_CAL;
        default:             docr_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Register map of this slice
  //   0x3a bits [1:0]  driver signalling code, bits [7:2] read zero
  //   0x3b bit 7       automatic bandwidth choice
  //   0x3b bit 3       integrator limit freeze
  //   0x3b other bits  read zero
  //   0x3c bits [7:0]  calibration low byte
  //   0x3d is outside this slice: writes ignored, reads zero
  // The upper calibration byte comes in as a level from outside
  // Limitation: unused bits are not stored, so reset values read back masked
  // Reads and writes take effect on the edge that samples the strobe
  // Read data stands until the next read
  // Both strobes in one cycle are legal; the read returns the old value

  // Stored configuration; unused bits are never stored
  reg  [7:0] diff_output_type_select_q;
  reg  [7:0] pll_bandwidth_auto_control_q;
  reg  [7:0] osc_calibration_low_byte_q;
  wire [2:0] reg_sel;
  wire       wr_diff_out;
  wire       wr_bw_ctrl;
  wire       wr_cal_lo;
  wire [1:0] diff_out_signalling_field;
  wire       automatic_bandwidth_choice;
  wire       integrator_limit_freeze;
  wire       freeze_d;

  // Address decode for the write strobes
  assign reg_sel     = docr_sel(reg_addr);
  assign wr_diff_out = reg_wr & (reg_sel == SEL_DIFF);
  assign wr_bw_ctrl  = reg_wr & (reg_sel == SEL_BW);
  assign wr_cal_lo   = reg_wr & (reg_sel == SEL_CAL);

  // Control fields
  assign diff_out_signalling_field  = diff_output_type_select_q[1:0]; // RULE1
  assign automatic_bandwidth_choice = pll_bandwidth_auto_control_q[`DOCR_BIT_AUTO_BW]; // RULE3
  assign integrator_limit_freeze    = pll_bandwidth_auto_control_q[`DOCR_BIT_LIM_INT]; // RULE4

  // Freeze acts in the same cycle as the limit so the report never slips a sample
  assign freeze_d = integrator_limit_freeze & freq_at_limit; // RULE4

  // Output type register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      diff_output_type_select_q <= `DOCR_RST_DIFF_OUT & `DOCR_MASK_DIFF_OUT;
    end else if (wr_diff_out) begin
      diff_output_type_select_q <= reg_wdata & `DOCR_MASK_DIFF_OUT; // RULE1
    end
  end

  // Bandwidth and limit register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pll_bandwidth_auto_control_q <= `DOCR_RST_BW_CTRL & `DOCR_MASK_BW_CTRL;
    end else if (wr_bw_ctrl) begin
      pll_bandwidth_auto_control_q <= reg_wdata & `DOCR_MASK_BW_CTRL;
    end
  end

  // Calibration low byte
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_calibration_low_byte_q <= `DOCR_RST_CAL_LO;
    end else if (wr_cal_lo) begin
      osc_calibration_low_byte_q <= reg_wdata; // RULE6
    end
  end

  // Read data registered; unmapped addresses return zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_sel)
        SEL_DIFF: reg_rdata <= diff_output_type_select_q;
        SEL_BW:   reg_rdata <= pll_bandwidth_auto_control_q;
        SEL_CAL:  reg_rdata <= osc_calibration_low_byte_q;
        default:  reg_rdata <= 8'h00;
      endcase
    end
  end

  // PECL line registered so the analog driver never sees decode glitches
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      diff_out_pecl <= 1'b0;
    end else begin
      diff_out_pecl <= docr_is_pecl(diff_out_signalling_field); // RULE2
    end
  end

  // LVDS line
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      diff_out_lvds <= 1'b0;
    end else begin
      diff_out_lvds <= docr_is_lvds(diff_out_signalling_field); // RULE2
    end
  end

  // Driver enable, off for both spare codes
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      diff_out_enable <= 1'b0;
    end else begin
      diff_out_enable <= docr_is_driven(diff_out_signalling_field); // RULE2
    end
  end

  // Acquisition only while auto mode is on and the loop is not yet locked
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      use_acq_bandwidth <= 1'b0;
    end else begin
      use_acq_bandwidth <= automatic_bandwidth_choice & ~pll_locked; // RULE3
    end
  end

  // Integrator freeze flag, a level that follows the limit
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      integrator_frozen <= 1'b0;
    end else begin
      integrator_frozen <= freeze_d; // RULE4
    end
  end

  // Hold the report while frozen so software sees the clamp value
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reported_pll_frequency <= 16'h0000;
    end else if (!freeze_d) begin
      reported_pll_frequency <= pll_freq_live; // RULE5
    end
  end

  // Trim word; the upper byte is only joined here, never stored
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_trim_word <= 16'h0000;
    end else begin
      osc_trim_word <= {cal_high_byte, osc_calibration_low_byte_q}; // RULE6
    end
  end

endmodule

// ===== testbench/docr_monitor.sv
`timescale 1ns/1ns
module docr_monitor (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        pll_locked,
  input wire logic        freq_at_limit,
  input wire logic        diff_out_enable,
  input wire logic        diff_out_pecl,
  input wire logic        diff_out_lvds,
  input wire logic        use_acq_bandwidth,
  input wire logic        integrator_frozen,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  cal_high_byte,
  input wire logic [15:0] pll_freq_live,
  input wire logic [15:0] reported_pll_frequency,
  input wire logic [15:0] osc_trim_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // A type write shows on the driver two edges later
  sequence s_out_wr; reg_wr && reg_addr == 8'h3A; endsequence
  a_pecl_code: assert property (s_out_wr |-> ##2 diff_out_pecl ==
    ($past(reg_wdata[1:0], 2) == 2'b01)) else $error("pecl decode wrong");
  a_lvds_code: assert property (s_out_wr |-> ##2 diff_out_lvds ==
    ($past(reg_wdata[1:0], 2) == 2'b10)) else $error("lvds decode wrong");
  a_enable_one: assert property (diff_out_enable == (diff_out_pecl ^ diff_out_lvds))
    else $error("enable not one mode");
  a_acq_unlocked: assert property (use_acq_bandwidth |-> !$past(pll_locked))
    else $error("acquisition while locked");
  a_freeze_limit: assert property (integrator_frozen |-> $past(freq_at_limit))
    else $error("freeze off limit");
  a_report_held: assert property (integrator_frozen |-> $stable(reported_pll_frequency))
    else $error("report moved");
  a_trim_join: assert property ($past(resetn) |-> osc_trim_word[15:8] == $past(cal_high_byte))
    else $error("trim high wrong");
endmodule
bind docr_regs docr_monitor mon_u (.*);

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, pll_locked = 0, freq_at_limit = 0;
  logic diff_out_enable, diff_out_pecl, diff_out_lvds, use_acq_bandwidth, integrator_frozen;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cal_high_byte = 8'h5A;
  logic [15:0] pll_freq_live = 0, reported_pll_frequency, osc_trim_word;
  int fails = 0, comparisons = 0;
  docr_regs dut_u (.*);
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n); repeat (n) @(posedge ref_clk); #1; endtask
  task automatic wr(input logic [7:0] a, d); reg_addr = a; reg_wdata = d; reg_wr = 1;
    cyc(1); reg_wr = 0; cyc(1); endtask
  // Read data is registered, so look after the strobe is dropped
  task automatic rd(input logic [7:0] a, e); reg_addr = a; reg_rd = 1;
    cyc(1); reg_rd = 0; cyc(1); chk(reg_rdata, e); endtask
  task automatic t_reset; rd(8'h3A, 8'h02); rd(8'h3B, 8'h88); rd(8'h3C, 8'h99);
    rd(8'h55, 8'h00); chk({diff_out_enable, diff_out_pecl, diff_out_lvds}, 3'b101); endtask
  task automatic t_decode; for (int c = 0; c < 4; c++) begin wr(8'h3A, 8'(c));
    chk({diff_out_enable, diff_out_pecl, diff_out_lvds}, {c == 1 || c == 2, c == 1, c == 2}); end
  endtask
  task automatic t_bw; wr(8'h3B, 8'h80); cyc(1); chk(use_acq_bandwidth, 1);
    pll_locked = 1; cyc(2); chk(use_acq_bandwidth, 0); wr(8'h3B, 8'h00);
    pll_locked = 0; cyc(2); chk(use_acq_bandwidth, 0); endtask
  task automatic t_freeze; freq_at_limit = 1; pll_freq_live = 16'h1234; cyc(2);
    chk(integrator_frozen, 0); wr(8'h3B, 8'h08); pll_freq_live = 16'h5678; cyc(2);
    chk(integrator_frozen, 1); chk(reported_pll_frequency, 16'h1234);
    freq_at_limit = 0; cyc(2); chk(reported_pll_frequency, 16'h5678);
    chk(integrator_frozen, 0); endtask
  task automatic t_trim; chk(osc_trim_word, 16'h5A99); wr(8'h3C, 8'h21);
    wr(8'h3D, 8'hFF); rd(8'h3C, 8'h21);
    cal_high_byte = 8'hC3; cyc(2); chk(osc_trim_word, 16'hC321); endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin #20000; fails++; finish_test; end
  initial begin cyc(12); resetn = 1; cyc(1); t_reset; t_trim; t_decode; t_bw; t_freeze;
    finish_test; end
endmodule
